// ===== ttm_monitor.sv
// ttm_monitor: active-low throttle pin monitor with AXI4-Lite register slave and one level interrupt
// assumes throttle_in_n is asynchronous to aclk; aresetn is the sleep-domain reset
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps

// Functional notes
// R1: period_done_flag sets on period counter one-to-zero; write-one clears, reset clears
// R2: long_assert_flag sets while assertion counter meets or exceeds limit
// R3: write-one clears long_assert_flag only when counter is below limit; the code also clears it while monitor_on is zero
// R4: optional filter drops pin pulses under three ticks before counters sample
// R5: block_soft_clear write-one resets whole monitor and self-clears; code leaves pin_sync, pin_level, hold_bytes and bus logic to aresetn
// R6: period interrupt raised only when period_done_flag set and its enable set
// R7: assertion interrupt raised only when long_assert_flag set and its enable set
// R8: pin_level_mirror follows pin while monitor_on, holds otherwise, resets to one
// R9: monitor_on zero freezes all counters and status; registers stay readable
// R10: byte-zero read latches upper bytes; narrow reads of them return held copy
// R11: 16-bit assertion counter counts ticks while pin low, zero while high
// R12: assertion counter saturates at all ones
// R13: limit of zero disables the compare
// R14: period counter reaches zero: copy active count, clear it, flag, reload
// R15: active counter counts low ticks; runs of fifty ticks or fewer discarded
// R16: period zero disables duty measurement; period write clears active counts
// R17: interrupt output is a level held while an enabled flag stays set; the code also gates it with irq_mask and the sticky irq_status bit
module ttm_monitor (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        throttle_in_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);

  // pin synchroniser: three stages, change accepted when stages two and three agree
  logic [2:0]  pin_sync;
  logic        pin_level;
  logic [15:0] tick_cnt;
  logic        tick;

  // registers
  logic        monitor_on, glitch_filter_on, period_irq_en, assert_irq_en;
  logic        period_done_flag, long_assert_flag, pin_level_mirror;
  logic [23:0] cumulative, duty_count, period_reg, period_cnt, run_cnt;
  logic [15:0] assert_cnt, limit_reg;
  logic [1:0]  irq_status, irq_mask;
  logic [23:0] hold_bytes;
  logic [1:0]  filt_cnt;
  logic        filt_level;

  // write channel capture so address and data may come in either order
  ttm_pkg::ttm_wreq_type wreq;
  logic        aw_have, w_have;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  wire soft_clear;
  wire do_write   = aw_have && w_have && !s_axi_bvalid;
  wire [4:0] waddr = wreq.addr[4:0];
  wire w_mapped   = waddr <= ttm_pkg::OFF_IRQ_MASK && wreq.addr[31:5] == 27'h0 && waddr[1:0] == 2'b00;
  // a refused write must not alias onto a mapped register through its low address bits
  wire wr_ok      = do_write && w_mapped;
  wire wr_ctrl    = wr_ok && waddr == ttm_pkg::OFF_CTRL;
  wire wr_period  = wr_ok && waddr == ttm_pkg::OFF_PERIOD && wreq.strb != 4'h0;
  wire wr_limit   = wr_ok && waddr == ttm_pkg::OFF_LIMIT;
  wire wr_status  = wr_ok && waddr == ttm_pkg::OFF_IRQ_STATUS;
  wire wr_mask    = wr_ok && waddr == ttm_pkg::OFF_IRQ_MASK;
  wire ctrl_lo    = wreq.strb[0];
  wire ctrl_hi    = wreq.strb[1];
  wire [31:0] wd  = wreq.data;

  // the soft clear is a combinational one-cycle decode of the captured write, ORed into the synchronous rst
  // R5: self-clearing soft clear when written with one
  assign soft_clear = wr_ctrl && ctrl_lo && wd[ttm_pkg::BIT_SOFT_CLEAR];
  wire rst = !aresetn || soft_clear;

  // stable pin: only stages two and three are compared, stage one feeds stage two alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_sync <= 3'h7;
    else
      pin_sync <= {pin_sync[1:0], throttle_in_n};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_level <= 1'b1;
    else if (pin_sync[2] == pin_sync[1])
      pin_level <= pin_sync[2];
  end

  // 100 kHz tick; stops while the monitor is off, standing in for gated clocks
  // R9: tick halted while monitor off
  wire tick_run = monitor_on;
  assign tick = tick_run && tick_cnt == 16'(ttm_pkg::TICK_CYCLES - 1);
  always_ff @(posedge aclk)
  begin
    if (rst || !tick_run || tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  // glitch filter: level must persist three ticks; sampling phase can shorten that by up to one
  // R4: drop pulses shorter than three ticks
  wire filt_diff = pin_level != filt_level;
  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      filt_cnt   <= 2'h0;
      filt_level <= 1'b1;
    end
    else if (tick)
    begin
      filt_cnt <= filt_diff ? filt_cnt + 2'h1 : 2'h0;
      if (filt_diff && filt_cnt == 2'(ttm_pkg::FILTER_TICKS - 1))
      begin
        filt_level <= pin_level;
        filt_cnt   <= 2'h0;
      end
    end
  end
  wire active_low = glitch_filter_on ? !filt_level : !pin_level;

  // assertion counter
  // R11: count while low, forced to zero while high; R12: saturate
  always_ff @(posedge aclk)
  begin
    if (rst)
      assert_cnt <= ttm_pkg::COUNT16_RESET;
    else if (tick)
      assert_cnt <= !active_low ? ttm_pkg::COUNT16_RESET :
                    (assert_cnt == ttm_pkg::COUNT16_MAX) ? assert_cnt : assert_cnt + 16'h0001;
  end

  // limit compare, held off when the limit is zero
  // R2: meet-or-exceed; R13: zero limit disables
  wire limit_hit = limit_reg != 16'h0000 && assert_cnt >= limit_reg;

  // duty-cycle counters; a run counts into run_cnt and only credits once past fifty ticks
  wire duty_on = monitor_on && period_reg != ttm_pkg::COUNT24_RESET;
  wire period_end = duty_on && tick && period_cnt == 24'h00_0001;
  wire run_valid  = run_cnt > 24'(ttm_pkg::MIN_ACTIVE_TICKS);
  // R15: credit a run of more than fifty ticks, discard shorter runs
  wire [23:0] credit = (!active_low && run_valid) ? run_cnt : 24'h00_0000;
  always_ff @(posedge aclk)
  begin
    // R16: period write or zero period clears active counts
    if (rst || wr_period || !duty_on && monitor_on)
    begin
      run_cnt    <= ttm_pkg::COUNT24_RESET;
      cumulative <= ttm_pkg::COUNT24_RESET;
      period_cnt <= wr_period ? wd[23:0] : period_reg;
    end
    else if (tick)
    begin
      run_cnt    <= active_low ? run_cnt + 24'h00_0001 : ttm_pkg::COUNT24_RESET;
      // R14: at zero copy, clear, reload
      if (period_end)
      begin
        cumulative <= ttm_pkg::COUNT24_RESET;
        period_cnt <= period_reg;
      end
      else
      begin
        cumulative <= cumulative + credit;
        period_cnt <= period_cnt - 24'h00_0001;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (rst)
      duty_count <= ttm_pkg::COUNT24_RESET;
    else if (period_end)
      duty_count <= cumulative + credit;
  end

  // control fields and sticky flags; a hardware set beats a same-cycle software clear
  // R9: flags set and mirror follows the pin only while monitor on; write-one clears of the flags act at any time
  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      {monitor_on, glitch_filter_on, period_irq_en, assert_irq_en} <= 4'h0;
      period_done_flag <= 1'b0;
      long_assert_flag <= 1'b0;
      pin_level_mirror <= ttm_pkg::CTRL_RESET[ttm_pkg::BIT_PIN_MIRROR];
      period_reg       <= ttm_pkg::COUNT24_RESET;
      limit_reg        <= ttm_pkg::COUNT16_RESET;
    end
    else
    begin
      if (wr_ctrl && ctrl_lo)
      begin
        monitor_on       <= wd[ttm_pkg::BIT_MONITOR_ON];
        glitch_filter_on <= wd[ttm_pkg::BIT_FILTER_ON];
        period_irq_en    <= wd[ttm_pkg::BIT_PERIOD_IRQ];
        assert_irq_en    <= wd[ttm_pkg::BIT_ASSERT_IRQ];
      end
      if (wr_period)
        period_reg <= wd[23:0];
      if (wr_limit)
        limit_reg <= wd[15:0];
      // R8: mirror follows pin while enabled
      if (monitor_on)
        pin_level_mirror <= pin_level;
      // R1: set on period end, write-one clear
      if (period_end)
        period_done_flag <= 1'b1;
      else if (wr_ctrl && ctrl_hi && wd[ttm_pkg::BIT_PERIOD_DONE])
        period_done_flag <= 1'b0;
      // R3: clear only once the limit is no longer met or the monitor is off
      if (monitor_on && limit_hit)
        long_assert_flag <= 1'b1;
      else if (wr_ctrl && ctrl_hi && wd[ttm_pkg::BIT_LONG_ASSERT])
        long_assert_flag <= 1'b0;
    end
  end

  // interrupt status: sticky on each period end and on the assertion flag's rise, write-one clear, set wins
  wire [1:0] irq_event;
  assign irq_event[ttm_pkg::IRQ_PERIOD] = period_end;
  assign irq_event[ttm_pkg::IRQ_ASSERT] = monitor_on && limit_hit && !long_assert_flag;
  always_ff @(posedge aclk)
  begin
    if (rst)
    begin
      irq_status <= ttm_pkg::IRQ_RESET;
      irq_mask   <= ttm_pkg::IRQ_RESET;
    end
    else
    begin
      irq_status <= irq_event | (irq_status & ~((wr_status && ctrl_lo) ? wd[1:0] : 2'h0));
      if (wr_mask && ctrl_lo)
        irq_mask <= wd[1:0];
    end
  end

  // R6: period interrupt gated by its enable; R7: assertion interrupt gated likewise
  // R17: level output while an enabled flag, its irq_mask bit and its irq_status bit all stay set
  wire period_irq = period_done_flag && period_irq_en && irq_mask[ttm_pkg::IRQ_PERIOD];
  wire assert_irq = long_assert_flag && assert_irq_en && irq_mask[ttm_pkg::IRQ_ASSERT];
  assign irq = (period_irq && irq_status[ttm_pkg::IRQ_PERIOD])
            || (assert_irq && irq_status[ttm_pkg::IRQ_ASSERT]);

  // write channel: accept address and data independently, answer once both are in
  assign s_axi_awready = !aw_have;
  assign s_axi_wready  = !w_have;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have      <= 1'b0;
      w_have       <= 1'b0;
      wreq         <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ttm_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have)
      begin
        aw_have   <= 1'b1;
        wreq.addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have)
      begin
        w_have    <= 1'b1;
        wreq.data <= s_axi_wdata;
        wreq.strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? ttm_pkg::RESP_OKAY : ttm_pkg::RESP_SLVERR;
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read decode; narrow reads are told apart by address low bits since AXI4-Lite has no size
  // R10: byte-zero read (address offset 0) latches upper bytes, offset 1..3 reads use the copy
  wire [4:0] raddr  = {s_axi_araddr[4:2], 2'b00};
  wire [1:0] rlane  = s_axi_araddr[1:0];
  wire r_mapped     = raddr <= ttm_pkg::OFF_IRQ_MASK && s_axi_araddr[31:5] == 27'h0;
  wire is_latched   = raddr == ttm_pkg::OFF_CUMULATIVE || raddr == ttm_pkg::OFF_DUTY_COUNT
                   || raddr == ttm_pkg::OFF_ASSERT_CNT;
  wire [31:0] ctrl_word = {20'h0_0000, period_done_flag, long_assert_flag, 4'h0, glitch_filter_on, 1'b0,
                           period_irq_en, assert_irq_en, pin_level_mirror, monitor_on};
  logic [31:0] live;
  always_comb
  begin
    unique case (raddr)
      ttm_pkg::OFF_CUMULATIVE: live = {8'h00, cumulative};
      ttm_pkg::OFF_DUTY_COUNT: live = {8'h00, duty_count};
      ttm_pkg::OFF_PERIOD:     live = {8'h00, period_reg};
      ttm_pkg::OFF_CTRL:       live = ctrl_word;
      ttm_pkg::OFF_ASSERT_CNT: live = {16'h0000, assert_cnt};
      ttm_pkg::OFF_LIMIT:      live = {16'h0000, limit_reg};
      ttm_pkg::OFF_IRQ_STATUS: live = {30'h0, irq_status};
      ttm_pkg::OFF_IRQ_MASK:   live = {30'h0, irq_mask};
      default:                 live = 32'h0000_0000;
    endcase
    next_rresp = r_mapped ? ttm_pkg::RESP_OKAY : ttm_pkg::RESP_SLVERR;
    next_rdata = (is_latched && rlane != 2'b00) ? {hold_bytes, 8'h00} : live;
  end

  // read channel: one outstanding read, answered the cycle after it is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ttm_pkg::RESP_OKAY;
      hold_bytes   <= ttm_pkg::COUNT24_RESET;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= r_mapped ? next_rdata : 32'h0000_0000;
      s_axi_rresp  <= next_rresp;
      if (is_latched && rlane == 2'b00)
        hold_bytes <= live[31:8];
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // ttm_monitor

// ===== ttm_pkg.sv
// ttm_pkg: register map, field positions, reset values and carrier types for the throttle pin monitor
// assumes a 125 MHz bus clock from which the 100 kHz tick is derived
package ttm_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_CUMULATIVE = 5'h00;
  localparam logic [4:0] OFF_DUTY_COUNT = 5'h04;
  localparam logic [4:0] OFF_PERIOD     = 5'h08;
  localparam logic [4:0] OFF_CTRL       = 5'h0c;
  localparam logic [4:0] OFF_ASSERT_CNT = 5'h10;
  localparam logic [4:0] OFF_LIMIT      = 5'h14;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h18;
  localparam logic [4:0] OFF_IRQ_MASK   = 5'h1c;

  // control/status field positions
  localparam int BIT_PERIOD_DONE = 11;
  localparam int BIT_LONG_ASSERT = 10;
  localparam int BIT_FILTER_ON   = 5;
  localparam int BIT_SOFT_CLEAR  = 4;
  localparam int BIT_PERIOD_IRQ  = 3;
  localparam int BIT_ASSERT_IRQ  = 2;
  localparam int BIT_PIN_MIRROR  = 1;
  localparam int BIT_MONITOR_ON  = 0;

  // interrupt status/mask layout
  localparam int IRQ_PERIOD = 0;
  localparam int IRQ_ASSERT = 1;

  // reset values
  localparam logic [15:0] CTRL_RESET      = 16'h0002;
  localparam logic [23:0] COUNT24_RESET   = 24'h00_0000;
  localparam logic [15:0] COUNT16_RESET   = 16'h0000;
  localparam logic [15:0] COUNT16_MAX     = 16'hffff;
  localparam logic [1:0]  IRQ_RESET       = 2'h0;

  // tick and filter timing
  localparam int CLK_HZ          = 125_000_000;
  localparam int TICK_HZ         = 100_000;
  localparam int TICK_CYCLES     = CLK_HZ / TICK_HZ;
  localparam int FILTER_TICKS    = 3;
  localparam int MIN_ACTIVE_TICKS = 50;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // one AXI4-Lite request carrier
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } ttm_wreq_type;

endpackage : ttm_pkg

// ===== ttm_pin_driver.sv
// pin driver model: platform source of the active-low throttle signal
// assumes a pull-up on the line, so the driver only ever pulls it low
`timescale 1ns/1ps
module ttm_pin_driver (
  input  wire logic aclk,
  input  wire logic pull_low,
  output logic      throttle_in_n
);
  // released line sits at the pull-up level
  initial throttle_in_n = 1'b1;
  // moves 3 ns after the edge so the pin is not aligned with aclk
  always @(posedge aclk)
  begin
    throttle_in_n <= #3 !pull_low;
  end
endmodule // ttm_pin_driver

// ===== ttm_monitor_properties.sv
// checker: bus handshake, error response and reset relations at the monitor ports
// assumes it is bound to ttm_monitor; one clock, synchronous active-low reset
`timescale 1ns/1ps
module ttm_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // address phases taken; offsets above the map must be refused
  sequence aw_bad;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr[31:5] != 27'h000_0000;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // answers come within one to three cycles and stand until taken
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
    else $error("write got no response");
  wr_refuse_a: assert property (aw_bad |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == ttm_pkg::RESP_SLVERR))
    else $error("unmapped write not refused");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read got no data");
  rd_refuse_a: assert property (ar_taken and s_axi_araddr[31:5] != 27'h000_0000 |=>
    s_axi_rresp == ttm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
  rd_okay_a: assert property (ar_taken and s_axi_araddr[31:5] == 27'h000_0000 |=> s_axi_rresp == ttm_pkg::RESP_OKAY)
    else $error("mapped read refused");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // a quiet interface right after reset, interrupt low
  rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && s_axi_arready)
    else $error("outputs busy after reset");
endmodule // ttm_checker

bind ttm_monitor ttm_checker u_ttm_checker (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// ===== tb_ttm_monitor.sv
// testbench: register-level tests of the throttle pin monitor
// assumes the pin driver model and the bound checker are compiled alongside
`timescale 1ns/1ps
module tb_ttm_monitor;
  logic        aclk, aresetn, pull_low, pin_n, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          fail_count = 0;
  int          check_count = 0;
  localparam logic [31:0] a_per  = {27'h000_0000, ttm_pkg::OFF_PERIOD};
  localparam logic [31:0] a_ctrl = {27'h000_0000, ttm_pkg::OFF_CTRL};
  localparam logic [31:0] a_cnt  = {27'h000_0000, ttm_pkg::OFF_ASSERT_CNT};
  localparam logic [31:0] a_lim  = {27'h000_0000, ttm_pkg::OFF_LIMIT};
  localparam logic [31:0] a_mask = {27'h000_0000, ttm_pkg::OFF_IRQ_MASK};
  localparam logic [31:0] a_stat = {27'h000_0000, ttm_pkg::OFF_IRQ_STATUS};

  ttm_pin_driver u_ttm_pin_driver (.aclk(aclk), .pull_low(pull_low), .throttle_in_n(pin_n));
  ttm_monitor u_ttm_monitor (.aclk(aclk), .aresetn(aresetn), .throttle_in_n(pin_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

  // 125 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // one bus access; ready is raised only once the answer shows, so hold paths get exercised
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    int   n;
    logic ad, wd, dn, ak, wk, ok, rv;
    begin
      ad = !w;
      wd = !w;
      dn = 1'b0;
      n = 0;
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      while (!dn && n < 100)
      begin
        @(negedge aclk);
        ak = (w ? awready : arready) && (w ? !ad : !arvalid ? 1'b0 : 1'b1);
        wk = wready && !wd;
        ok = w ? (bvalid && bready) : (rvalid && rready);
        rv = w ? bvalid : rvalid;
        q = rdata;
        resp = w ? bresp : rresp;
        @(posedge aclk);
        if (ak)
        begin
          awvalid <= 1'b0;
          arvalid <= 1'b0;
          ad = 1'b1;
        end
        if (wk)
        begin
          wvalid <= 1'b0;
          wd = 1'b1;
        end
        if (ok)
        begin
          bready <= 1'b0;
          rready <= 1'b0;
          dn = 1'b1;
        end
        else if (rv)
        begin
          bready <= w;
          rready <= !w;
        end
        n++;
      end
      if (!dn)
      begin
        fail_count++;
        $display("unexpected at %0t: bus hung", $time);
      end
    end
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      check_count++;
      if (got !== exp)
      begin
        fail_count++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  // wait whole 100 kHz ticks
  task automatic tk(input int n);
    repeat (n * ttm_pkg::TICK_CYCLES) @(posedge aclk);
  endtask

  task automatic wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // about 30 ticks of tests; the limit leaves about double
  initial
  begin
    #600_000;
    fail_count++;
    $display("unexpected at %0t: timeout", $time);
    wrap_up();
  end

  // main sequence
  initial
  begin
    aresetn <= 1'b0;
    pull_low <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, wdata, araddr} <= 96'h0;
    wstrb <= 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    acc(1'b0, a_ctrl, 0);
    chk(q, 32'h0000_0002);
    acc(1'b0, a_cnt, 0);
    chk(q, 32'h0000_0000);
    acc(1'b0, 32'h0000_0040, 0);
    chk({30'h0000_0000, resp}, 32'h0000_0002);
    // unmapped write whose low bits alias the control register must be refused and ignored
    acc(1'b1, 32'h0000_004c, 32'h0000_0001);
    chk({30'h0000_0000, resp}, 32'h0000_0002);
    // disabled monitor ignores a low pin
    pull_low <= 1'b1;
    tk(3);
    acc(1'b0, a_ctrl, 0);
    chk(q, 32'h0000_0002);
    acc(1'b0, a_cnt, 0);
    chk(q, 32'h0000_0000);
    pull_low <= 1'b0;
    // long assertion, limit one, unfiltered
    acc(1'b1, a_lim, 32'h0000_0001);
    acc(1'b1, a_mask, 32'h0000_0003);
    acc(1'b1, a_ctrl, 32'h0000_0005);
    pull_low <= 1'b1;
    tk(4);
    acc(1'b0, a_ctrl, 0);
    chk(q, 32'h0000_0405);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    acc(1'b1, a_ctrl, 32'h0000_0405);
    acc(1'b0, a_ctrl, 0);
    chk(q, 32'h0000_0405);
    pull_low <= 1'b0;
    tk(2);
    acc(1'b0, a_cnt, 0);
    chk(q, 32'h0000_0000);
    acc(1'b1, a_ctrl, 32'h0000_0405);
    acc(1'b0, a_ctrl, 0);
    chk(q, 32'h0000_0007);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    // two-tick glitch is removed by the filter; let the filter settle high before enabling it
    tk(2);
    acc(1'b1, a_ctrl, 32'h0000_0025);
    tk(2);
    pull_low <= 1'b1;
    tk(2);
    pull_low <= 1'b0;
    tk(5);
    acc(1'b0, a_ctrl, 0);
    chk(q, 32'h0000_0027);
    // zero limit never flags
    acc(1'b1, a_lim, 0);
    pull_low <= 1'b1;
    tk(5);
    acc(1'b0, a_ctrl, 0);
    chk({30'h0000_0000, q[11:10]}, 32'h0000_0000);
    pull_low <= 1'b0;
    // period of two ticks; work right after the event, far from the next
    acc(1'b1, a_mask, 32'h0000_0001);
    acc(1'b1, a_per, 32'h0000_0002);
    acc(1'b1, a_ctrl, 32'h0000_0009);
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge aclk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    // both events were latched in the sticky status; write-one clears the assertion event only
    acc(1'b0, a_stat, 0);
    chk(q, 32'h0000_0003);
    acc(1'b1, a_stat, 32'h0000_0002);
    acc(1'b0, a_stat, 0);
    chk(q, 32'h0000_0001);
    acc(1'b1, a_ctrl, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    acc(1'b0, a_ctrl, 0);
    chk({31'h0000_0000, q[11]}, 32'h0000_0001);
    acc(1'b1, a_ctrl, 32'h0000_0801);
    acc(1'b0, a_ctrl, 0);
    chk({31'h0000_0000, q[11]}, 32'h0000_0000);
    // soft clear returns the control and period registers to reset
    acc(1'b1, a_ctrl, 32'h0000_0010);
    acc(1'b0, a_ctrl, 0);
    chk(q, 32'h0000_0002);
    acc(1'b0, a_per, 0);
    chk(q, 32'h0000_0000);
    wrap_up();
  end
endmodule // tb_ttm_monitor
